// *** hdl/araf_pkg.sv ***
package araf_pkg;
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_ACC_CFG  = 4'h1;
  localparam logic [3:0] REG_RES_LO   = 4'h2;
  localparam logic [3:0] REG_RES_HI   = 4'h3;
  localparam logic [3:0] REG_STATUS   = 4'h4;
  localparam logic [3:0] REG_IMASK    = 4'h5;
  localparam logic [3:0] REG_WIN_LO_L = 4'h6;
  localparam logic [3:0] REG_WIN_LO_H = 4'h7;
  localparam logic [3:0] REG_WIN_HI_L = 4'h8;
  localparam logic [3:0] REG_WIN_HI_H = 4'h9;
  localparam logic [3:0] REG_PWRUP    = 4'ha;
  localparam int CTRL_START = 0;
  localparam int CTRL_BURST = 1;
  localparam int CTRL_IDLE_ON = 2;
  localparam int CFG_SJST_LSB = 0;
  localparam int CFG_RPT_LSB  = 3;
  localparam int ST_DONE = 0;
  localparam int ST_WIN  = 1;
  localparam logic [2:0] SJST_RIGHT = 3'h0;
  localparam logic [2:0] SJST_LEFT  = 3'h4;
  localparam logic [7:0] PWRUP_RESET = 8'h04;
  localparam int CLK_HZ = 10_000_000;
  localparam int MAX_SPS = 300_000;
  localparam int CONV_MIN_CYCLES = (CLK_HZ + MAX_SPS - 1) / MAX_SPS;
  typedef enum logic [2:0] {ARAF_IDLE, ARAF_PWRUP, ARAF_CONV, ARAF_WAIT} araf_state_e;
endpackage : araf_pkg

// *** hdl/araf_formatter.sv ***
`timescale 1ns/100ps
module araf_formatter
  import araf_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        load,
  input  wire logic [15:0] sum,
  input  wire logic [2:0]  sjst,
  output logic      [15:0] result
);
  typedef struct packed {
    logic [15:0] res;
  } araf_fmt_s;
  araf_fmt_s s_q, s_d;
  always_comb begin
    s_d = s_q;
    if (load) begin
      unique case (sjst)
        SJST_RIGHT: s_d.res = sum;
        3'h1: s_d.res = {1'b0, sum[15:1]};
        3'h2: s_d.res = {2'b00, sum[15:2]};
        3'h3: s_d.res = {3'b000, sum[15:3]};
        SJST_LEFT: s_d.res = {sum[9:0], 6'h00};
        default: s_d.res = sum;
      endcase
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) s_q <= '0;
    else s_q <= s_d;
  end
  assign result = s_q.res;
endmodule : araf_formatter

// *** hdl/araf_top.sv ***
`timescale 1ns/100ps
module araf_top
  import araf_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_MIN_CYCLES
)
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       conv_start,
  output logic            conv_go,
  input  wire logic       code_valid,
  input  wire logic [9:0] code,
  output logic            sar_converter_en,
  output logic            conversion_done_flag,
  output logic            window_hit,
  output logic            irq
);
  typedef struct packed {
    araf_state_e st;
    logic        burst_enable_bit;
    logic        idle_on;
    logic [2:0]  justify_shift_field;
    logic [2:0]  repeat_count_field;
    logic [15:0] acc;
    logic [6:0]  cnt;
    logic [7:0]  tmr;
    logic [7:0]  pwrup;
    logic [1:0]  status;
    logic [1:0]  imask;
    logic [15:0] win_lo;
    logic [15:0] win_hi;
    logic        load;
    logic        cmp;
    logic        go;
    logic        en;
    logic        irq;
    logic [7:0]  rdata;
  } araf_top_s;
  araf_top_s s_q, s_d;
  logic [15:0] result;
  logic [6:0]  series_len;
  logic        sw_start;
  logic        start;
  logic        in_hit;
  logic [15:0] acc_next;
  araf_formatter araf_formatter_i (
    .clock  (clock),
    .rstn   (rstn),
    .load   (s_q.load),
    .sum    (s_q.acc),
    .sjst   (s_q.justify_shift_field),
    .result (result)
  );
  always_comb begin
    unique case (s_q.repeat_count_field)
      3'h1: series_len = 7'd4;
      3'h2: series_len = 7'd8;
      3'h3: series_len = 7'd16;
      3'h4: series_len = 7'd32;
      3'h5: series_len = 7'd64;
      default: series_len = 7'd1;
    endcase
  end
  assign sw_start = wr && addr == REG_CTRL && wdata[CTRL_START];
  assign start    = sw_start || conv_start;
  assign acc_next = s_q.acc + {6'h00, code};
  assign in_hit   = result >= s_q.win_lo && result <= s_q.win_hi;
  always_comb begin
    s_d       = s_q;
    s_d.load  = 1'b0;
    s_d.cmp   = s_q.load;
    s_d.go    = 1'b0;
    s_d.rdata = 8'h00;
    if (wr) begin
      unique case (addr)
        REG_CTRL: begin
          s_d.burst_enable_bit = wdata[CTRL_BURST];
          s_d.idle_on          = wdata[CTRL_IDLE_ON];
        end
        REG_ACC_CFG: begin
          s_d.justify_shift_field = wdata[CFG_SJST_LSB +: 3];
          s_d.repeat_count_field  = wdata[CFG_RPT_LSB +: 3];
        end
        REG_STATUS:   s_d.status = s_q.status & ~wdata[1:0];
        REG_IMASK:    s_d.imask = wdata[1:0];
        REG_WIN_LO_L: s_d.win_lo[7:0] = wdata;
        REG_WIN_LO_H: s_d.win_lo[15:8] = wdata;
        REG_WIN_HI_L: s_d.win_hi[7:0] = wdata;
        REG_WIN_HI_H: s_d.win_hi[15:8] = wdata;
        REG_PWRUP:    s_d.pwrup = wdata;
        default: ;
      endcase
    end
    if (rd) begin
      unique case (addr)
        REG_CTRL:     s_d.rdata = {5'h00, s_q.idle_on, s_q.burst_enable_bit, s_q.st != ARAF_IDLE};
        REG_ACC_CFG:  s_d.rdata = {2'b00, s_q.repeat_count_field, s_q.justify_shift_field};
        REG_RES_LO:   s_d.rdata = result[7:0];
        REG_RES_HI:   s_d.rdata = result[15:8];
        REG_STATUS:   s_d.rdata = {6'h00, s_q.status};
        REG_IMASK:    s_d.rdata = {6'h00, s_q.imask};
        REG_WIN_LO_L: s_d.rdata = s_q.win_lo[7:0];
        REG_WIN_LO_H: s_d.rdata = s_q.win_lo[15:8];
        REG_WIN_HI_L: s_d.rdata = s_q.win_hi[7:0];
        REG_WIN_HI_H: s_d.rdata = s_q.win_hi[15:8];
        REG_PWRUP:    s_d.rdata = s_q.pwrup;
        default:      s_d.rdata = 8'h00;
      endcase
    end
    if (s_q.cmp && in_hit) s_d.status[ST_WIN] = 1'b1;
    unique case (s_q.st)
      ARAF_IDLE: begin
        s_d.en = s_q.burst_enable_bit ? s_q.idle_on : 1'b1;
        if (start) begin
          if (s_q.cnt == 7'd0) s_d.acc = 16'h0000;
          s_d.en = 1'b1;
          if (s_q.burst_enable_bit && !s_q.en) begin
            s_d.tmr = s_q.pwrup;
            s_d.st  = ARAF_PWRUP;
          end else begin
            s_d.go  = 1'b1;
            s_d.tmr = 8'(CONV_CYCLES);
            s_d.st  = ARAF_CONV;
          end
        end
      end
      ARAF_PWRUP: begin
        if (s_q.tmr == 8'h00) begin
          s_d.go  = 1'b1;
          s_d.tmr = 8'(CONV_CYCLES);
          s_d.st  = ARAF_CONV;
        end else s_d.tmr = s_q.tmr - 8'h01;
      end
      ARAF_CONV: begin
        if (s_q.tmr != 8'h00) s_d.tmr = s_q.tmr - 8'h01;
        if (code_valid) begin
          s_d.acc = acc_next;
          s_d.st  = ARAF_WAIT;
          if (s_q.cnt + 7'd1 >= series_len) begin
            s_d.cnt  = 7'd0;
            s_d.load = 1'b1;
            s_d.status[ST_DONE] = 1'b1;
          end else s_d.cnt = s_q.cnt + 7'd1;
        end
      end
      ARAF_WAIT: begin
        if (s_q.tmr != 8'h00) s_d.tmr = s_q.tmr - 8'h01;
        else if (s_q.burst_enable_bit && s_q.cnt != 7'd0) begin
          s_d.go  = 1'b1;
          s_d.tmr = 8'(CONV_CYCLES);
          s_d.st  = ARAF_CONV;
        end else begin
          s_d.st = ARAF_IDLE;
          if (s_q.burst_enable_bit) s_d.en = s_q.idle_on;
        end
      end
      default: s_d.st = ARAF_IDLE;
    endcase
    s_d.irq = |(s_d.status & s_q.imask);
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q       <= '0;
      s_q.st    <= ARAF_IDLE;
      s_q.pwrup <= PWRUP_RESET;
      s_q.win_hi <= 16'hffff;
    end else s_q <= s_d;
  end
  assign rdata                = s_q.rdata;
  assign conv_go              = s_q.go;
  assign sar_converter_en     = s_q.en;
  assign conversion_done_flag = s_q.status[ST_DONE];
  assign window_hit           = s_q.status[ST_WIN];
  assign irq                  = s_q.irq;
endmodule : araf_top

// *** bench/araf_top_sva.sv ***
`timescale 1ns/100ps
module araf_top_sva
  import araf_pkg::*;
#(
  parameter int CONV_CYCLES = 8
)
(
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       conv_go,
  input wire logic       code_valid,
  input wire logic       sar_converter_en,
  input wire logic       conversion_done_flag,
  input wire logic       window_hit,
  input wire logic       irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_RDATA_ZERO: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_DONE_CAUSE: assert property ($rose(conversion_done_flag) |-> $past(code_valid))
    else $error("done flag rose without a final code");
  AST_DONE_CLEAR: assert property (wr && addr == REG_STATUS && wdata[ST_DONE] && !code_valid
    |=> !conversion_done_flag)
    else $error("done flag not cleared by write one");
  AST_DONE_FALL: assert property ($fell(conversion_done_flag)
    |-> $past(wr && addr == REG_STATUS && wdata[ST_DONE]))
    else $error("done flag fell without a clear");
  AST_WIN_CAUSE: assert property ($rose(window_hit) |-> $past(code_valid, 3))
    else $error("window hit not tied to completed result");
  AST_GO_SPACE: assert property (conv_go |=> !conv_go [*7])
    else $error("conversions launched too close");
  AST_EN_GO: assert property ($rose(sar_converter_en) |-> ##[1:20] conv_go)
    else $error("powered converter never launched");
  AST_IRQ_CAUSE: assert property (irq |-> conversion_done_flag || window_hit)
    else $error("interrupt without status bit");
endmodule : araf_top_sva

bind araf_top araf_top_sva #(.CONV_CYCLES(CONV_CYCLES)) araf_top_sva_i (.clock, .rstn, .addr,
  .wdata, .wr, .rd, .rdata, .conv_go, .code_valid, .sar_converter_en, .conversion_done_flag,
  .window_hit, .irq);

// *** bench/araf_top_tb.sv ***
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module araf_top_tb
  import araf_pkg::*;
;
  logic        clock = 0, rstn = 0, wr = 0, rd = 0, conv_start = 0, code_valid = 0;
  logic [3:0]  addr = 0;
  logic [7:0]  wdata = 0, rdata, lo, hi;
  logic [9:0]  code = 0;
  logic        conv_go, sar_converter_en, conversion_done_flag, window_hit, irq;
  logic [32:0] r;
  int          mismatches = 0, n_checks = 0;
  // burst, repeat, justify, code, expected result
  logic [32:0] rows [10] = '{
    {1'h1, 3'h0, 3'h0, 10'h3ff, 16'h03ff}, {1'h0, 3'h0, 3'h4, 10'h3ff, 16'hffc0},
    {1'h1, 3'h1, 3'h0, 10'h3ff, 16'h0ffc}, {1'h0, 3'h1, 3'h1, 10'h3ff, 16'h07fe},
    {1'h1, 3'h2, 3'h0, 10'h200, 16'h1000}, {1'h1, 3'h3, 3'h2, 10'h3ff, 16'h0ffc},
    {1'h1, 3'h4, 3'h0, 10'h1ff, 16'h3fe0}, {1'h1, 3'h5, 3'h3, 10'h3ff, 16'h1ff8},
    {1'h1, 3'h5, 3'h0, 10'h3ff, 16'hffc0}, {1'h0, 3'h0, 3'h3, 10'h3ff, 16'h007f}};

  always #50 clock = ~clock;

  araf_top #(.CONV_CYCLES(8)) araf_top_i (.clock, .rstn, .addr, .wdata, .wr, .rd, .rdata,
    .conv_start, .conv_go, .code_valid, .code, .sar_converter_en, .conversion_done_flag,
    .window_hit, .irq);

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // one conversion: own start when not bursting, answer the launch with a code
  task automatic sample(input logic st, input logic [9:0] c);
    int k;
    k = 0;
    if (st) begin
      repeat (8) @(posedge clock);
      conv_start <= 1'b1;
      @(posedge clock);
      conv_start <= 1'b0;
    end
    #1;
    while (conv_go !== 1'b1 && k < 300) begin
      @(posedge clock);
      #1 k++;
    end
    @(posedge clock);
    code_valid <= 1'b1;
    code <= c;
    @(posedge clock);
    code_valid <= 1'b0;
  endtask : sample

  task automatic tally_and_finish;
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  initial begin
    #1_000_000 mismatches++;
    tally_and_finish();
  end

  initial begin
    @(posedge clock);
    #1 `CHK("reset outs", 5'h00, {conv_go, sar_converter_en, conversion_done_flag, window_hit, irq})
    @(posedge clock);
    @(posedge clock);
    rstn <= 1'b1;
    wr_reg(REG_IMASK, 8'h01);
    foreach (rows[i]) begin
      r = rows[i];
      wr_reg(REG_ACC_CFG, {2'h0, r[31:29], r[28:26]});
      wr_reg(REG_CTRL, {6'h0, r[32], r[32]});
      for (int j = 0; j < (r[31:29] != 0 ? 2 << r[31:29] : 1); j++) begin
        `CHK("early done", 1'b0, conversion_done_flag)
        sample(!r[32], r[25:16]);
      end
      repeat (3) @(posedge clock);
      rd_reg(REG_RES_LO, lo);
      rd_reg(REG_RES_HI, hi);
      `CHK("result", r[15:0], {hi, lo})
      `CHK("done", 1'b1, conversion_done_flag)
      `CHK("window", 1'b1, window_hit)
      `CHK("irq", 1'b1, irq)
      wr_reg(REG_STATUS, 8'h03);
    end
    rd_reg(4'hf, lo);
    `CHK("unmapped", 8'h00, lo)
    wr_reg(REG_ACC_CFG, 8'h00);
    wr_reg(REG_WIN_LO_H, 8'h01);
    wr_reg(REG_CTRL, 8'h03);
    sample(1'b0, 10'h001);
    repeat (8) @(posedge clock);
    `CHK("powered down", 1'b0, sar_converter_en)
    wr_reg(REG_STATUS, 8'h03);
    wr_reg(REG_CTRL, 8'h03);
    sample(1'b0, 10'h002);
    repeat (3) @(posedge clock);
    rd_reg(REG_RES_LO, lo);
    rd_reg(REG_RES_HI, hi);
    `CHK("burst wake", 16'h0002, {hi, lo})
    `CHK("no window", 1'b0, window_hit)
    rstn <= 1'b0;
    @(posedge clock);
    #1 `CHK("reset again", 5'h00, {conv_go, sar_converter_en, conversion_done_flag, window_hit, irq})
    @(posedge clock);
    rstn <= 1'b1;
    wr_reg(REG_IMASK, 8'h00);
    wr_reg(REG_ACC_CFG, 8'h00);
    wr_reg(REG_CTRL, 8'h00);
    sample(1'b1, 10'h155);
    repeat (3) @(posedge clock);
    rd_reg(REG_RES_LO, lo);
    rd_reg(REG_RES_HI, hi);
    `CHK("single", 16'h0155, {hi, lo})
    `CHK("masked irq", 1'b0, irq)
    wr_reg(REG_STATUS, 8'h01);
    #1 `CHK("cleared", 1'b0, conversion_done_flag)
    tally_and_finish();
  end
endmodule : araf_top_tb
